// [hw/cpm_pkg.sv]
/*
 Constants and state type for the clock and power status monitor bank.
 Assumes a single control clock domain and a synchronous active-high reset.
*/
package cpm_pkg;

	localparam logic [7:0] CPM_PLL_STATE_OFFSET = 8'h69;
	localparam logic [7:0] CPM_ANALOG_POWER_OFFSET = 8'h6A;
	localparam logic [7:0] CPM_PROTECT_RESET_OFFSET = 8'h6B;

	// Clock status register layout
	localparam int CPM_PLL_ON_BIT = 4;
	localparam int CPM_SPARE_HI_MSB = 7;
	localparam int CPM_SPARE_HI_LSB = 5;
	localparam int CPM_SPARE_LO_BIT = 3;
	localparam int CPM_SOURCE_MSB = 2;
	localparam int CPM_SOURCE_LSB = 0;
	localparam logic [3:0] CPM_SPARE_RESET = 4'h0;

	// Analog power monitor layout
	localparam int CPM_CHARGE_PUMP_BIT = 7;
	localparam int CPM_ANALOG_REF_BIT = 6;
	localparam int CPM_LINE_DRIVER_BIT = 5;
	localparam int CPM_LINE_BIAS_BIT = 4;
	localparam int CPM_LINE_FEEDBACK_BIT = 3;
	localparam int CPM_LEFT_STAGE_BIT = 2;
	localparam int CPM_RIGHT_STAGE_BIT = 1;
	localparam int CPM_DAC_BIT = 0;

	// Protection and reset monitor layout
	localparam int CPM_OFFSET_COMP_BIT = 7;
	localparam int CPM_SHORT_PROTECT_BIT = 6;
	localparam int CPM_IMP_SENSE_BIT = 5;
	localparam int CPM_IMP_ALL_BIT = 4;
	localparam int CPM_LEFT_SHORT_BIT = 3;
	localparam int CPM_RIGHT_SHORT_BIT = 2;
	localparam int CPM_MODULATOR_BIT = 1;
	localparam int CPM_ELEMENT_MATCH_BIT = 0;

	// Reference source codes
	localparam logic [2:0] CPM_SRC_MASTER_CLOCK = 3'h0;
	localparam logic [2:0] CPM_SRC_BIT_CLOCK = 3'h1;
	localparam logic [2:0] CPM_SRC_INTERNAL_OSCILLATOR = 3'h2;
	localparam logic [2:0] CPM_SRC_GP_PIN = 3'h3;

	localparam logic [7:0] CPM_UNMAPPED_READ = 8'h00;
	localparam logic [7:0] CPM_RDATA_RESET = 8'h00;
	localparam logic [2:0] CPM_SOURCE_RESET = 3'h0;

	// Layout of the synchronised status vector
	localparam int CPM_STATUS_WIDTH = 17;
	localparam int CPM_STATUS_PLL_BIT = 16;
	localparam int CPM_STATUS_ANALOG_LSB = 8;
	localparam int CPM_STATUS_PROTECT_LSB = 0;

	typedef struct packed {
		logic [3:0] spare;
		logic [7:0] rdata;
		logic rd_valid;
		logic mute;
		logic [2:0] source;
	} cpm_state_t;

endpackage

// [hw/cpm_sync.sv]
/*
 Two-flop synchroniser bank for status levels from other sub-blocks.
 Assumes inputs are slow levels; multi-bit values are not coherent.
*/
`timescale 1ns/1ps
module cpm_sync #(
	parameter int WIDTH = 17
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} cpm_sync_state_t;

	cpm_sync_state_t state;
	cpm_sync_state_t next_state;

	// Meta stage feeds only the stable stage
	always_comb begin
		next_state.meta = async_in;
		next_state.stable = state.meta;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign sync_out = state.stable;

endmodule

// [hw/cpm_monitor.sv]
/*
 Clock, power and reset status monitor bank behind the control port's
 register access path: one read-only clock status register with spare
 read/write bits, and two read-only power and reset monitor registers.
 Assumes the control port delivers single-cycle read and write strobes
 with an 8-bit register address in the sys_clk domain, and that the
 sub-block status levels arrive asynchronously.
*/
// Contract
// - Clock status bit 4 shows PLL enabled
// - Three-bit source field encodes four sources
// - Reserved source codes force the output mute
// - Source shows auto choice or register choice
// - Analog bit 7 shows charge pump power
// - Analog bit 6 shows analog reference power
// - Analog bit 5 shows line driver power
// - Analog bit 4 shows line bias power
// - Analog bit 3 shows line feedback power
// - Analog bit 2 shows left stage power
// - Analog bit 1 shows right stage power
// - Analog bit 0 shows DAC power
// - Protection bit 7 shows offset compensator power
// - Protection bit 6 shows short protector power
// - Protection bit 5 shows impedance sense power
// - Protection bit 4 shows whole impedance power
// - Protection bit 3 shows left short reset
// - Protection bit 2 shows right short reset
// - Protection bit 1 shows modulator reset
// - Protection bit 0 shows element matching reset
// - Clock status spare bits writable, reset zero
`timescale 1ns/1ps
module cpm_monitor (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rd_valid,
	input wire logic auto_clock_en,
	input wire logic [2:0] auto_source,
	input wire logic [2:0] reg_source,
	input wire logic pll_on_flag,
	input wire logic charge_pump_power_flag,
	input wire logic analog_ref_power_flag,
	input wire logic line_driver_power_flag,
	input wire logic line_bias_power_flag,
	input wire logic line_feedback_power_flag,
	input wire logic left_stage_power_flag,
	input wire logic right_stage_power_flag,
	input wire logic dac_power_flag,
	input wire logic offset_comp_power_flag,
	input wire logic short_protect_power_flag,
	input wire logic impedance_sense_power_flag,
	input wire logic impedance_all_power_flag,
	input wire logic left_short_reset_flag,
	input wire logic right_short_reset_flag,
	input wire logic modulator_reset_flag,
	input wire logic element_matching_reset_flag,
	output logic [2:0] pll_source_select,
	output logic source_mute
);

	cpm_pkg::cpm_state_t state;
	cpm_pkg::cpm_state_t next_state;

	logic [cpm_pkg::CPM_STATUS_WIDTH-1:0] status_raw;
	logic [cpm_pkg::CPM_STATUS_WIDTH-1:0] status_sync;
	logic [7:0] analog_raw;
	logic [7:0] protect_raw;
	logic [7:0] analog_byte;
	logic [7:0] protect_byte;
	logic [7:0] pll_byte;
	logic [2:0] chosen_source;

	// True for any code outside the four defined sources
	function automatic logic cpm_source_reserved(input logic [2:0] code);
		logic res;
		res = 1'b1;
		if (code == cpm_pkg::CPM_SRC_MASTER_CLOCK ||
			code == cpm_pkg::CPM_SRC_BIT_CLOCK ||
			code == cpm_pkg::CPM_SRC_INTERNAL_OSCILLATOR ||
			code == cpm_pkg::CPM_SRC_GP_PIN) begin
			res = 1'b0;
		end
		return res;
	endfunction

	// Place the analog power levels at their bit positions
	always_comb begin
		analog_raw = 8'h00;
		analog_raw[cpm_pkg::CPM_CHARGE_PUMP_BIT] = charge_pump_power_flag;
		analog_raw[cpm_pkg::CPM_ANALOG_REF_BIT] = analog_ref_power_flag;
		analog_raw[cpm_pkg::CPM_LINE_DRIVER_BIT] = line_driver_power_flag;
		analog_raw[cpm_pkg::CPM_LINE_BIAS_BIT] = line_bias_power_flag;
		analog_raw[cpm_pkg::CPM_LINE_FEEDBACK_BIT] = line_feedback_power_flag;
		analog_raw[cpm_pkg::CPM_LEFT_STAGE_BIT] = left_stage_power_flag;
		analog_raw[cpm_pkg::CPM_RIGHT_STAGE_BIT] = right_stage_power_flag;
		analog_raw[cpm_pkg::CPM_DAC_BIT] = dac_power_flag;
	end

	// Place the protection power and reset levels
	always_comb begin
		protect_raw = 8'h00;
		protect_raw[cpm_pkg::CPM_OFFSET_COMP_BIT] = offset_comp_power_flag;
		protect_raw[cpm_pkg::CPM_SHORT_PROTECT_BIT] = short_protect_power_flag;
		protect_raw[cpm_pkg::CPM_IMP_SENSE_BIT] = impedance_sense_power_flag;
		protect_raw[cpm_pkg::CPM_IMP_ALL_BIT] = impedance_all_power_flag;
		protect_raw[cpm_pkg::CPM_LEFT_SHORT_BIT] = left_short_reset_flag;
		protect_raw[cpm_pkg::CPM_RIGHT_SHORT_BIT] = right_short_reset_flag;
		protect_raw[cpm_pkg::CPM_MODULATOR_BIT] = modulator_reset_flag;
		protect_raw[cpm_pkg::CPM_ELEMENT_MATCH_BIT] = element_matching_reset_flag;
	end

	assign status_raw = {pll_on_flag, analog_raw, protect_raw};

	// Levels come from other sub-blocks, so resynchronise before reading
	cpm_sync #(
		.WIDTH(cpm_pkg::CPM_STATUS_WIDTH)
	) u_status_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(status_raw),
		.sync_out(status_sync)
	);

	assign analog_byte = status_sync[cpm_pkg::CPM_STATUS_ANALOG_LSB +: 8];
	assign protect_byte = status_sync[cpm_pkg::CPM_STATUS_PROTECT_LSB +: 8];

	// Source select inputs share this clock, no resync needed
	always_comb begin
		if (auto_clock_en) begin
			chosen_source = auto_source;
		end else begin
			chosen_source = reg_source;
		end
	end

	// Clock status byte as software sees it
	always_comb begin
		pll_byte = 8'h00;
		pll_byte[cpm_pkg::CPM_SPARE_HI_MSB:cpm_pkg::CPM_SPARE_HI_LSB] =
			state.spare[3:1];
		pll_byte[cpm_pkg::CPM_SPARE_LO_BIT] = state.spare[0];
		pll_byte[cpm_pkg::CPM_PLL_ON_BIT] =
			status_sync[cpm_pkg::CPM_STATUS_PLL_BIT];
		pll_byte[cpm_pkg::CPM_SOURCE_MSB:cpm_pkg::CPM_SOURCE_LSB] =
			state.source;
	end

	always_comb begin
		next_state = state;
		next_state.rd_valid = 1'b0;
		next_state.source = chosen_source;
		next_state.mute = cpm_source_reserved(chosen_source);
		// Only the spare bits hold write data; monitor bits are not stored
		if (reg_wr && reg_addr == cpm_pkg::CPM_PLL_STATE_OFFSET) begin
			next_state.spare = {
				reg_wdata[cpm_pkg::CPM_SPARE_HI_MSB:cpm_pkg::CPM_SPARE_HI_LSB],
				reg_wdata[cpm_pkg::CPM_SPARE_LO_BIT]
			};
		end
		// Reads only sample; nothing they return is altered by them
		if (reg_rd) begin
			next_state.rd_valid = 1'b1;
			if (reg_addr == cpm_pkg::CPM_PLL_STATE_OFFSET) begin
				next_state.rdata = pll_byte;
			end else if (reg_addr == cpm_pkg::CPM_ANALOG_POWER_OFFSET) begin
				next_state.rdata = analog_byte;
			end else if (reg_addr == cpm_pkg::CPM_PROTECT_RESET_OFFSET) begin
				next_state.rdata = protect_byte;
			end else begin
				next_state.rdata = cpm_pkg::CPM_UNMAPPED_READ;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state.spare <= cpm_pkg::CPM_SPARE_RESET;
			state.rdata <= cpm_pkg::CPM_RDATA_RESET;
			state.rd_valid <= 1'b0;
			state.mute <= 1'b0;
			state.source <= cpm_pkg::CPM_SOURCE_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign reg_rdata = state.rdata;
	assign reg_rd_valid = state.rd_valid;
	assign pll_source_select = state.source;
	assign source_mute = state.mute;

endmodule

// [test/cpm_monitor_checker.sv]
/*
 Checker for the status monitor bank's read port and source outputs.
 Assumes it is bound to cpm_monitor and sees only its ports.
*/
`timescale 1ns/1ps
module cpm_monitor_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rd_valid,
	input wire logic auto_clock_en,
	input wire logic [2:0] auto_source,
	input wire logic [2:0] reg_source,
	input wire logic pll_on_flag,
	input wire logic [2:0] pll_source_select,
	input wire logic source_mute
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	AST_RD_ANSWER: assert property (reg_rd |=> reg_rd_valid)
		else $error("read got no answer");
	AST_RD_PULSE: assert property (!reg_rd |=> !reg_rd_valid)
		else $error("answer without read");
	AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	AST_AUTO_SRC: assert property (auto_clock_en |=>
		pll_source_select == $past(auto_source)) else $error("auto source");
	AST_REG_SRC: assert property (!auto_clock_en |=>
		pll_source_select == $past(reg_source)) else $error("reg source");
	AST_MUTE: assert property (source_mute == (pll_source_select > 3'h3))
		else $error("mute does not match source code");
	AST_UNMAPPED: assert property (reg_rd && (reg_addr < 8'h69 ||
		reg_addr > 8'h6B) |=> reg_rdata == 8'h00) else $error("unmapped");
	// Sync delay: flag must be steady two edges before the read counts
	AST_PLL_ON: assert property (reg_rd && reg_addr == 8'h69 &&
		$stable(pll_on_flag) && pll_on_flag == $past(pll_on_flag, 2) &&
		!$past(rst) && !$past(rst, 2) |=> reg_rdata[4] == $past(pll_on_flag))
		else $error("pll on bit wrong");
endmodule
bind cpm_monitor cpm_monitor_checker cpm_monitor_checker_i (.*);

// [test/cpm_monitor_bench.sv]
/*
 Self-checking bench for the status monitor bank against a byte model.
 Assumes cpm_monitor and its checker are compiled first.
*/
`timescale 1ns/1ps
module cpm_monitor_bench;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic auto_clock_en = 1'b0;
	logic pll = 1'b0;
	logic [2:0] auto_source = 3'h0;
	logic [2:0] reg_source = 3'h0;
	logic [7:0] an = 8'h00;
	logic [7:0] pr = 8'h00;
	logic [7:0] reg_rdata;
	logic reg_rd_valid;
	logic [2:0] pll_source_select;
	logic source_mute;
	logic [31:0] rnd = 32'h59E6;
	logic [3:0] sp = 4'h0;
	logic [2:0] src = 3'h0;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	cpm_monitor cpm_monitor_i (.sys_clk(sys_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
		.auto_clock_en(auto_clock_en), .auto_source(auto_source),
		.reg_source(reg_source), .pll_on_flag(pll), .dac_power_flag(an[0]),
		.charge_pump_power_flag(an[7]), .analog_ref_power_flag(an[6]),
		.line_driver_power_flag(an[5]), .line_bias_power_flag(an[4]),
		.line_feedback_power_flag(an[3]), .left_stage_power_flag(an[2]),
		.right_stage_power_flag(an[1]), .modulator_reset_flag(pr[1]),
		.offset_comp_power_flag(pr[7]), .short_protect_power_flag(pr[6]),
		.impedance_sense_power_flag(pr[5]), .left_short_reset_flag(pr[3]),
		.impedance_all_power_flag(pr[4]), .right_short_reset_flag(pr[2]),
		.element_matching_reset_flag(pr[0]),
		.pll_source_select(pll_source_select), .source_mute(source_mute));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Two spare edges let the status synchronisers refill
	task automatic reset_dut();
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		sp = 4'h0;
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk({7'h00, reg_rd_valid}, 8'h01);
		chk(reg_rdata, exp);
	endtask
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		reset_dut();
		rd(8'h69, 8'h00);
		for (int i = 0; i < 24; i++) begin
			@(posedge sys_clk);
			rnd = lfsr(rnd);
			an <= rnd[7:0];
			pr <= rnd[15:8];
			pll <= rnd[16];
			auto_clock_en <= i[3];
			auto_source <= ~i[2:0];
			reg_source <= i[2:0];
			repeat (3) @(posedge sys_clk);
			src = auto_clock_en ? auto_source : reg_source;
			#1;
			chk({5'h00, pll_source_select}, {5'h00, src});
			chk({7'h00, source_mute}, {7'h00, src > 3'h3});
			wr(8'h69, rnd[31:24]);
			sp = {rnd[31:29], rnd[27]};
			wr(8'h6A, ~rnd[7:0]);
			wr(8'h6B, ~rnd[15:8]);
			rd(8'h6A, an);
			rd(8'h6B, pr);
			rd(8'h69, {sp[3:1], pll, sp[0], src});
			rd(i[0] ? 8'h6C : 8'h68, 8'h00);
		end
		// Set every spare bit so the reset check can trip
		wr(8'h69, 8'hFF);
		reset_dut();
		rd(8'h69, {sp[3:1], pll, sp[0], src});
		end_sim();
	end
endmodule
